// [rtl/kbgp_pad_drv.sv]
`timescale 1ns/10ps
`default_nettype none
module kbgp_pad_drv #(
   parameter logic [7:0] IMPL_MASK = 8'hff,
   parameter bit OPEN_DRAIN = 1'b1
) (
   input wire logic mclk_i,
   input wire logic arst_n_i,
   input wire logic [7:0] latch_i,
   input wire logic [7:0] dir_i,
   output logic [7:0] pin_o,
   output logic [7:0] pin_oe_o
);

   logic [7:0] pin_q;
   logic [7:0] oe_q;

   // ----------------------------------------------------------------
   // output stage
   // ----------------------------------------------------------------
   // open drain only ever pulls low: enable while latch is zero
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pin_q <= kbgp_pkg::KBGP_ZERO;
         oe_q <= kbgp_pkg::KBGP_ZERO;
      end else if (OPEN_DRAIN) begin
         pin_q <= kbgp_pkg::KBGP_ZERO; // R01 R02 R09
         oe_q <= dir_i & ~latch_i & IMPL_MASK; // R11
      end else begin
         pin_q <= latch_i & IMPL_MASK; // R11
         oe_q <= dir_i & IMPL_MASK; // R11
      end
   end

   assign pin_o = pin_q;
   assign pin_oe_o = oe_q;

   a_drive_follow: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      $past(arst_n_i) && OPEN_DRAIN |->
      oe_q == ($past(dir_i) & ~$past(latch_i) & IMPL_MASK) && pin_q == 8'h00) // R11
      else $error("open drain enable does not follow direction and latch");

endmodule : kbgp_pad_drv
`default_nettype wire

// [rtl/kbgp_pkg.sv]
package kbgp_pkg;

   // ----------------------------------------------------------------
   // bus widths
   // ----------------------------------------------------------------
   localparam int KBGP_AW = 6;
   localparam int KBGP_DW = 8;
   localparam int KBGP_BW = 3;

   // ----------------------------------------------------------------
   // i/o register addresses
   // ----------------------------------------------------------------
   localparam logic [5:0] KBGP_E_PIN_ADDR = 6'h01;
   localparam logic [5:0] KBGP_E_DIR_ADDR = 6'h02;
   localparam logic [5:0] KBGP_E_LAT_ADDR = 6'h03;
   localparam logic [5:0] KBGP_D_PIN_ADDR = 6'h10;
   localparam logic [5:0] KBGP_D_DIR_ADDR = 6'h11;
   localparam logic [5:0] KBGP_D_LAT_ADDR = 6'h12;
   localparam logic [5:0] KBGP_C_PIN_ADDR = 6'h13;
   localparam logic [5:0] KBGP_C_DIR_ADDR = 6'h14;
   localparam logic [5:0] KBGP_C_LAT_ADDR = 6'h15;
   localparam logic [5:0] KBGP_B_PIN_ADDR = 6'h16;
   localparam logic [5:0] KBGP_B_DIR_ADDR = 6'h17;
   localparam logic [5:0] KBGP_B_LAT_ADDR = 6'h18;
   localparam logic [5:0] KBGP_A_PIN_ADDR = 6'h19;
   localparam logic [5:0] KBGP_A_DIR_ADDR = 6'h1a;
   localparam logic [5:0] KBGP_A_LAT_ADDR = 6'h1b;

   // ----------------------------------------------------------------
   // implemented bits and reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] KBGP_FULL_MASK = 8'hff;
   localparam logic [7:0] KBGP_D_MASK = 8'h03;
   localparam logic [7:0] KBGP_E_MASK = 8'hf3;
   localparam logic [7:0] KBGP_RST_VAL = 8'h00;
   localparam logic [7:0] KBGP_ZERO = 8'h00;
   localparam logic [7:0] KBGP_ONE_HOT0 = 8'h01;
   localparam logic [7:0] KBGP_PULL_ON = 8'hff;

endpackage : kbgp_pkg

// [rtl/kbgp_ports.sv]
// How it works
// R01: port a is eight bidirectional column pins whose outputs only pull low.
// R02: port b is a second eight-pin open-drain column port that behaves like port a.
// R03: port c is eight row pins with a pull-up on each, so an undriven row senses as one.
// R04: port d has two pins; its pin-sense location holds bits 1..0 and the rest read zero.
// R05: port e holds bits 1..0 and 7..4 as open-drain drivers, and bits 3..2 read zero.
// R06: reading a latch location gives the stored latch, reading pin-sense gives the pins.
// R07: pin-sense locations store nothing and writes to them change no state.
// R08: latch and direction registers are read/write and clear to zero on reset.
// R09: port c outputs only sink current when driven.
// R10: single-bit set and clear touch only the addressed bit of a register.
// R11: direction one drives the latch value onto the pin, direction zero releases it.
// R12: pin levels go through a two-flop synchroniser before the processor sees them.
`timescale 1ns/10ps
`default_nettype none
module kbgp_ports (
   input wire logic mclk_i,
   input wire logic arst_n_i,
   input wire logic [5:0] io_addr_i,
   input wire logic [7:0] io_wdata_i,
   input wire logic io_wr_i,
   input wire logic io_rd_i,
   input wire logic io_bset_i,
   input wire logic io_bclr_i,
   input wire logic [2:0] io_bit_i,
   output logic [7:0] io_rdata_o,
   input wire logic [7:0] port_a_pin_i,
   output logic [7:0] port_a_pin_o,
   output logic [7:0] port_a_pin_oe_o,
   input wire logic [7:0] port_b_pin_i,
   output logic [7:0] port_b_pin_o,
   output logic [7:0] port_b_pin_oe_o,
   input wire logic [7:0] port_c_pin_i,
   output logic [7:0] port_c_pin_o,
   output logic [7:0] port_c_pin_oe_o,
   output logic [7:0] port_c_pull_en_o,
   input wire logic [1:0] port_d_pin_i,
   output logic [1:0] port_d_pin_o,
   output logic [1:0] port_d_pin_oe_o,
   input wire logic [7:0] port_e_pin_i,
   output logic [7:0] port_e_pin_o,
   output logic [7:0] port_e_pin_oe_o
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [7:0] port_a_out_latch_q;
   logic [7:0] port_a_direction_q;
   logic [7:0] port_b_out_latch_q;
   logic [7:0] port_b_direction_q;
   logic [7:0] port_c_out_latch_q;
   logic [7:0] port_c_direction_q;
   logic [7:0] port_d_out_latch_q;
   logic [7:0] port_d_direction_q;
   logic [7:0] port_e_out_latch_q;
   logic [7:0] port_e_direction_q;
   logic [7:0] pull_en_q;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;

   logic [7:0] sense_a;
   logic [7:0] sense_b;
   logic [7:0] sense_c;
   logic [7:0] sense_d;
   logic [7:0] sense_e;
   logic [7:0] d_pin_o_w;
   logic [7:0] d_pin_oe_w;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // full write, bit set or bit clear on one register; a full write
   // wins if the core ever raises more than one strobe
   function automatic logic [7:0] kbgp_next(
      input logic [7:0] old,
      input logic [5:0] own,
      input logic [7:0] mask,
      input logic [5:0] addr,
      input logic [7:0] wdata,
      input logic wr,
      input logic bset,
      input logic bclr,
      input logic [2:0] bitn
   );
      logic [7:0] sel;
      sel = kbgp_pkg::KBGP_ONE_HOT0 << bitn;
      if (addr != own) begin // R07
         kbgp_next = old;
      end else if (wr) begin
         kbgp_next = wdata & mask;
      end else if (bset) begin
         kbgp_next = (old | sel) & mask; // R10
      end else if (bclr) begin
         kbgp_next = old & ~sel & mask; // R10
      end else begin
         kbgp_next = old;
      end
   endfunction : kbgp_next

   // ----------------------------------------------------------------
   // output latches
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         port_a_out_latch_q <= kbgp_pkg::KBGP_RST_VAL; // R08
         port_b_out_latch_q <= kbgp_pkg::KBGP_RST_VAL; // R08
         port_c_out_latch_q <= kbgp_pkg::KBGP_RST_VAL; // R08
         port_d_out_latch_q <= kbgp_pkg::KBGP_RST_VAL; // R08
         port_e_out_latch_q <= kbgp_pkg::KBGP_RST_VAL; // R08
      end else begin
         port_a_out_latch_q <= kbgp_next(port_a_out_latch_q, kbgp_pkg::KBGP_A_LAT_ADDR,
            kbgp_pkg::KBGP_FULL_MASK, io_addr_i, io_wdata_i, io_wr_i, io_bset_i,
            io_bclr_i, io_bit_i); // R01
         port_b_out_latch_q <= kbgp_next(port_b_out_latch_q, kbgp_pkg::KBGP_B_LAT_ADDR,
            kbgp_pkg::KBGP_FULL_MASK, io_addr_i, io_wdata_i, io_wr_i, io_bset_i,
            io_bclr_i, io_bit_i); // R02
         port_c_out_latch_q <= kbgp_next(port_c_out_latch_q, kbgp_pkg::KBGP_C_LAT_ADDR,
            kbgp_pkg::KBGP_FULL_MASK, io_addr_i, io_wdata_i, io_wr_i, io_bset_i,
            io_bclr_i, io_bit_i); // R03
         port_d_out_latch_q <= kbgp_next(port_d_out_latch_q, kbgp_pkg::KBGP_D_LAT_ADDR,
            kbgp_pkg::KBGP_D_MASK, io_addr_i, io_wdata_i, io_wr_i, io_bset_i,
            io_bclr_i, io_bit_i); // R04
         port_e_out_latch_q <= kbgp_next(port_e_out_latch_q, kbgp_pkg::KBGP_E_LAT_ADDR,
            kbgp_pkg::KBGP_E_MASK, io_addr_i, io_wdata_i, io_wr_i, io_bset_i,
            io_bclr_i, io_bit_i); // R05
      end
   end

   // ----------------------------------------------------------------
   // direction registers
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         port_a_direction_q <= kbgp_pkg::KBGP_RST_VAL; // R08
         port_b_direction_q <= kbgp_pkg::KBGP_RST_VAL; // R08
         port_c_direction_q <= kbgp_pkg::KBGP_RST_VAL; // R08
         port_d_direction_q <= kbgp_pkg::KBGP_RST_VAL; // R08
         port_e_direction_q <= kbgp_pkg::KBGP_RST_VAL; // R08
      end else begin
         port_a_direction_q <= kbgp_next(port_a_direction_q, kbgp_pkg::KBGP_A_DIR_ADDR,
            kbgp_pkg::KBGP_FULL_MASK, io_addr_i, io_wdata_i, io_wr_i, io_bset_i,
            io_bclr_i, io_bit_i); // R01
         port_b_direction_q <= kbgp_next(port_b_direction_q, kbgp_pkg::KBGP_B_DIR_ADDR,
            kbgp_pkg::KBGP_FULL_MASK, io_addr_i, io_wdata_i, io_wr_i, io_bset_i,
            io_bclr_i, io_bit_i); // R02
         port_c_direction_q <= kbgp_next(port_c_direction_q, kbgp_pkg::KBGP_C_DIR_ADDR,
            kbgp_pkg::KBGP_FULL_MASK, io_addr_i, io_wdata_i, io_wr_i, io_bset_i,
            io_bclr_i, io_bit_i); // R03
         port_d_direction_q <= kbgp_next(port_d_direction_q, kbgp_pkg::KBGP_D_DIR_ADDR,
            kbgp_pkg::KBGP_D_MASK, io_addr_i, io_wdata_i, io_wr_i, io_bset_i,
            io_bclr_i, io_bit_i); // R04
         port_e_direction_q <= kbgp_next(port_e_direction_q, kbgp_pkg::KBGP_E_DIR_ADDR,
            kbgp_pkg::KBGP_E_MASK, io_addr_i, io_wdata_i, io_wr_i, io_bset_i,
            io_bclr_i, io_bit_i); // R05
      end
   end

   // ----------------------------------------------------------------
   // pull-ups
   // ----------------------------------------------------------------
   // row pull-ups are fixed on; the pad merges them with the sink
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pull_en_q <= kbgp_pkg::KBGP_PULL_ON;
      end else begin
         pull_en_q <= kbgp_pkg::KBGP_PULL_ON; // R03
      end
   end

   // ----------------------------------------------------------------
   // pad drivers
   // ----------------------------------------------------------------
   kbgp_pad_drv #(.IMPL_MASK(kbgp_pkg::KBGP_FULL_MASK), .OPEN_DRAIN(1'b1)) u_drv_a (
      .mclk_i(mclk_i),
      .arst_n_i(arst_n_i),
      .latch_i(port_a_out_latch_q),
      .dir_i(port_a_direction_q),
      .pin_o(port_a_pin_o),
      .pin_oe_o(port_a_pin_oe_o)
   );

   kbgp_pad_drv #(.IMPL_MASK(kbgp_pkg::KBGP_FULL_MASK), .OPEN_DRAIN(1'b1)) u_drv_b (
      .mclk_i(mclk_i),
      .arst_n_i(arst_n_i),
      .latch_i(port_b_out_latch_q),
      .dir_i(port_b_direction_q),
      .pin_o(port_b_pin_o),
      .pin_oe_o(port_b_pin_oe_o)
   );

   kbgp_pad_drv #(.IMPL_MASK(kbgp_pkg::KBGP_FULL_MASK), .OPEN_DRAIN(1'b1)) u_drv_c (
      .mclk_i(mclk_i),
      .arst_n_i(arst_n_i),
      .latch_i(port_c_out_latch_q),
      .dir_i(port_c_direction_q),
      .pin_o(port_c_pin_o),
      .pin_oe_o(port_c_pin_oe_o)
   );

   // port d is a plain push-pull port
   kbgp_pad_drv #(.IMPL_MASK(kbgp_pkg::KBGP_D_MASK), .OPEN_DRAIN(1'b0)) u_drv_d (
      .mclk_i(mclk_i),
      .arst_n_i(arst_n_i),
      .latch_i(port_d_out_latch_q),
      .dir_i(port_d_direction_q),
      .pin_o(d_pin_o_w),
      .pin_oe_o(d_pin_oe_w)
   );

   kbgp_pad_drv #(.IMPL_MASK(kbgp_pkg::KBGP_E_MASK), .OPEN_DRAIN(1'b1)) u_drv_e (
      .mclk_i(mclk_i),
      .arst_n_i(arst_n_i),
      .latch_i(port_e_out_latch_q),
      .dir_i(port_e_direction_q),
      .pin_o(port_e_pin_o),
      .pin_oe_o(port_e_pin_oe_o)
   );

   // ----------------------------------------------------------------
   // pin sense synchronisers
   // ----------------------------------------------------------------
   kbgp_sync u_sync_a (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .async_i(port_a_pin_i),
      .sync_o(sense_a));
   kbgp_sync u_sync_b (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .async_i(port_b_pin_i),
      .sync_o(sense_b));
   kbgp_sync u_sync_c (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .async_i(port_c_pin_i),
      .sync_o(sense_c));
   kbgp_sync u_sync_d (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
      .async_i({6'h00, port_d_pin_i}), .sync_o(sense_d));
   kbgp_sync u_sync_e (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .async_i(port_e_pin_i),
      .sync_o(sense_e));

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   // pin-sense reads see levels two clocks old; software polling a row
   // right after driving a column must allow for that
   always_comb begin
      unique case (io_addr_i)
         kbgp_pkg::KBGP_A_PIN_ADDR: rdata_d = sense_a; // R06 R12
         kbgp_pkg::KBGP_A_DIR_ADDR: rdata_d = port_a_direction_q; // R08
         kbgp_pkg::KBGP_A_LAT_ADDR: rdata_d = port_a_out_latch_q; // R06
         kbgp_pkg::KBGP_B_PIN_ADDR: rdata_d = sense_b; // R06 R12
         kbgp_pkg::KBGP_B_DIR_ADDR: rdata_d = port_b_direction_q; // R08
         kbgp_pkg::KBGP_B_LAT_ADDR: rdata_d = port_b_out_latch_q; // R06
         kbgp_pkg::KBGP_C_PIN_ADDR: rdata_d = sense_c; // R03 R06
         kbgp_pkg::KBGP_C_DIR_ADDR: rdata_d = port_c_direction_q; // R08
         kbgp_pkg::KBGP_C_LAT_ADDR: rdata_d = port_c_out_latch_q; // R06
         kbgp_pkg::KBGP_D_PIN_ADDR: rdata_d = sense_d & kbgp_pkg::KBGP_D_MASK; // R04
         kbgp_pkg::KBGP_D_DIR_ADDR: rdata_d = port_d_direction_q; // R08
         kbgp_pkg::KBGP_D_LAT_ADDR: rdata_d = port_d_out_latch_q; // R06
         kbgp_pkg::KBGP_E_PIN_ADDR: rdata_d = sense_e & kbgp_pkg::KBGP_E_MASK; // R05
         kbgp_pkg::KBGP_E_DIR_ADDR: rdata_d = port_e_direction_q; // R08
         kbgp_pkg::KBGP_E_LAT_ADDR: rdata_d = port_e_out_latch_q; // R06
         default: rdata_d = kbgp_pkg::KBGP_ZERO;
      endcase
   end

   // read data holds until the next read strobe
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rdata_q <= kbgp_pkg::KBGP_ZERO;
      end else if (io_rd_i) begin
         rdata_q <= rdata_d; // R06
      end
   end

   assign io_rdata_o = rdata_q;
   assign port_c_pull_en_o = pull_en_q;
   assign port_d_pin_o = d_pin_o_w[1:0];
   assign port_d_pin_oe_o = d_pin_oe_w[1:0];

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!arst_n_i);

   logic pin_addr_hit;
   assign pin_addr_hit = io_addr_i == kbgp_pkg::KBGP_A_PIN_ADDR
      || io_addr_i == kbgp_pkg::KBGP_B_PIN_ADDR || io_addr_i == kbgp_pkg::KBGP_C_PIN_ADDR
      || io_addr_i == kbgp_pkg::KBGP_D_PIN_ADDR || io_addr_i == kbgp_pkg::KBGP_E_PIN_ADDR;

   a_col_a_open_drain: assert property (port_a_pin_o == 8'h00) // R01
      else $error("port a drives high");
   a_col_b_match: assert property ($past(arst_n_i) |->
      port_b_pin_oe_o == ($past(port_b_direction_q) & ~$past(port_b_out_latch_q))) // R02
      else $error("port b enable mismatch");
   a_row_pullup: assert property (port_c_pull_en_o == 8'hff) // R03
      else $error("row pull-up released");
   a_d_upper_zero: assert property (io_rd_i && io_addr_i == kbgp_pkg::KBGP_D_PIN_ADDR
      |=> io_rdata_o[7:2] == 6'h00) // R04
      else $error("port d upper sense bits not zero");
   a_e_gap_zero: assert property (port_e_out_latch_q[3:2] == 2'h0
      && port_e_direction_q[3:2] == 2'h0 && port_e_pin_oe_o[3:2] == 2'h0) // R05
      else $error("port e bits 3..2 implemented");
   a_latch_readback: assert property (io_wr_i && io_addr_i == kbgp_pkg::KBGP_A_LAT_ADDR
      ##1 io_rd_i && io_addr_i == kbgp_pkg::KBGP_A_LAT_ADDR && !io_wr_i && !io_bset_i
      && !io_bclr_i |=> io_rdata_o == $past(io_wdata_i, 2)) // R06
      else $error("latch readback wrong");
   a_sense_no_store: assert property ((io_wr_i || io_bset_i || io_bclr_i) && pin_addr_hit
      |=> $stable(port_a_out_latch_q) && $stable(port_c_direction_q)
      && $stable(port_e_out_latch_q) && $stable(port_b_direction_q)) // R07
      else $error("pin-sense write changed state");
   a_dir_write: assert property (io_wr_i && io_addr_i == kbgp_pkg::KBGP_C_DIR_ADDR
      |=> port_c_direction_q == $past(io_wdata_i)) // R08
      else $error("direction write lost");
   a_row_sink_only: assert property (port_c_pin_o == 8'h00) // R09
      else $error("row port sources current");
   a_bit_isolate: assert property (io_bset_i && !io_wr_i
      && io_addr_i == kbgp_pkg::KBGP_B_DIR_ADDR |=>
      port_b_direction_q == ($past(port_b_direction_q)
      | (kbgp_pkg::KBGP_ONE_HOT0 << $past(io_bit_i)))) // R10
      else $error("bit set disturbed other bits");
   a_push_pull_d: assert property ($past(arst_n_i) |->
      port_d_pin_oe_o == $past(port_d_direction_q[1:0])
      && port_d_pin_o == $past(port_d_out_latch_q[1:0])) // R11
      else $error("port d drive mismatch");
   a_sense_latency: assert property ($past(arst_n_i, 3) && io_rd_i
      && io_addr_i == kbgp_pkg::KBGP_C_PIN_ADDR |=> io_rdata_o == $past(port_c_pin_i, 3)) // R12
      else $error("row sense not two flops behind");

   a_d_latch_mask: assert property (port_d_out_latch_q[7:2] == 6'h00
      && port_d_direction_q[7:2] == 6'h00) // R04
      else $error("port d upper latch bits implemented");
   a_c_enable_match: assert property ($past(arst_n_i) |->
      port_c_pin_oe_o == ($past(port_c_direction_q) & ~$past(port_c_out_latch_q))) // R09
      else $error("port c enable mismatch");

   c_col_drive_low: cover property (port_a_pin_oe_o != 8'h00);
   c_row_read: cover property (io_rd_i && io_addr_i == kbgp_pkg::KBGP_C_PIN_ADDR);
   c_bit_clear: cover property (io_bclr_i && io_addr_i == kbgp_pkg::KBGP_E_LAT_ADDR);
   c_led_on: cover property (port_e_pin_oe_o[7:4] != 4'h0);
   c_back_to_back: cover property (io_wr_i ##1 io_rd_i);

endmodule : kbgp_ports
`default_nettype wire

// [rtl/kbgp_sync.sv]
`timescale 1ns/10ps
`default_nettype none
module kbgp_sync (
   input wire logic mclk_i,
   input wire logic arst_n_i,
   input wire logic [7:0] async_i,
   output logic [7:0] sync_o
);

   logic [7:0] meta_q;
   logic [7:0] sync_q;

   // ----------------------------------------------------------------
   // two stages; the first is read only by the second
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         meta_q <= kbgp_pkg::KBGP_ZERO;
         sync_q <= kbgp_pkg::KBGP_ZERO;
      end else begin
         meta_q <= async_i; // R12
         sync_q <= meta_q; // R12
      end
   end

   assign sync_o = sync_q;

   a_sync_delay: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      $past(arst_n_i, 2) |-> sync_q == $past(async_i, 2)) // R12
      else $error("sync output not two cycles behind input");

endmodule : kbgp_sync
`default_nettype wire

// [sim/kbgp_matrix_model.sv]
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// keyboard matrix, column loads and led side of the ports
// ----------------------------------------------------------------
module kbgp_matrix_model (
   input wire logic mclk_i,
   input wire logic [7:0] a_oe_i,
   input wire logic [7:0] b_oe_i,
   input wire logic [7:0] c_oe_i,
   input wire logic [7:0] c_pull_i,
   input wire logic [1:0] d_o_i,
   input wire logic [1:0] d_oe_i,
   input wire logic [7:0] e_oe_i,
   input wire logic [7:0] ext_a_i,
   input wire logic [7:0] ext_b_i,
   input wire logic [1:0] ext_d_i,
   input wire logic [7:0] ext_e_i,
   input wire logic key_dn_i,
   input wire logic [2:0] key_row_i,
   input wire logic [2:0] key_col_i,
   output logic [7:0] a_lvl_o,
   output logic [7:0] b_lvl_o,
   output logic [7:0] c_lvl_o,
   output logic [1:0] d_lvl_o,
   output logic [7:0] e_lvl_o
);
   // an unpulled row floats: toggle so a missing pull-up never reads as a clean one
   logic tog_q = 1'b0;
   always @(posedge mclk_i) begin
      tog_q <= ~tog_q;
   end
   always_comb begin
      a_lvl_o = ext_a_i & ~a_oe_i;
      b_lvl_o = ext_b_i & ~b_oe_i;
      e_lvl_o = ext_e_i & ~e_oe_i;
      d_lvl_o = (d_oe_i & d_o_i) | (~d_oe_i & ext_d_i);
      for (int r = 0; r < 8; r++) begin
         c_lvl_o[r] = c_pull_i[r] ? 1'b1 : tog_q;
         if (key_dn_i && key_row_i == r[2:0] && !a_lvl_o[key_col_i]) begin
            c_lvl_o[r] = 1'b0;
         end
         if (c_oe_i[r]) begin
            c_lvl_o[r] = 1'b0;
         end
      end
   end
endmodule : kbgp_matrix_model
`default_nettype wire

// [sim/test_keyboard_gpio_ports.sv]
`timescale 1ns/10ps
`default_nettype none
module test_keyboard_gpio_ports;
   logic mclk_i, arst_n_i, io_wr_i, io_rd_i, io_bset_i, io_bclr_i, key_dn;
   logic [5:0] io_addr_i;
   logic [7:0] io_wdata_i, io_rdata_o, a_pin, a_o, a_oe, b_pin, b_o, b_oe, ext_a, ext_b, ext_e;
   logic [7:0] c_pin, c_o, c_oe, c_pull, e_pin, e_o, e_oe;
   logic [2:0] io_bit_i, key_row, key_col;
   logic [1:0] d_pin, d_o, d_oe, ext_d;
   int error_cnt, checks_done;
   logic [5:0] rw_addr [10] = '{6'h1a, 6'h1b, 6'h17, 6'h18, 6'h14, 6'h15, 6'h11, 6'h12, 6'h02, 6'h03};
   logic [7:0] rw_mask [10] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h03, 8'h03, 8'hf3, 8'hf3};
   logic [5:0] pin_addr [5] = '{6'h19, 6'h16, 6'h13, 6'h10, 6'h01};

   kbgp_ports kbgp_ports_i (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .io_addr_i(io_addr_i),
      .io_wdata_i(io_wdata_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_bset_i(io_bset_i),
      .io_bclr_i(io_bclr_i), .io_bit_i(io_bit_i), .io_rdata_o(io_rdata_o),
      .port_a_pin_i(a_pin), .port_a_pin_o(a_o), .port_a_pin_oe_o(a_oe),
      .port_b_pin_i(b_pin), .port_b_pin_o(b_o), .port_b_pin_oe_o(b_oe),
      .port_c_pin_i(c_pin), .port_c_pin_o(c_o), .port_c_pin_oe_o(c_oe),
      .port_c_pull_en_o(c_pull), .port_d_pin_i(d_pin), .port_d_pin_o(d_o),
      .port_d_pin_oe_o(d_oe), .port_e_pin_i(e_pin), .port_e_pin_o(e_o), .port_e_pin_oe_o(e_oe));
   kbgp_matrix_model kbgp_matrix_model_i (.mclk_i(mclk_i), .a_oe_i(a_oe), .b_oe_i(b_oe),
      .c_oe_i(c_oe), .c_pull_i(c_pull), .d_o_i(d_o), .d_oe_i(d_oe), .e_oe_i(e_oe),
      .ext_a_i(ext_a), .ext_b_i(ext_b), .ext_d_i(ext_d), .ext_e_i(ext_e), .key_dn_i(key_dn),
      .key_row_i(key_row), .key_col_i(key_col), .a_lvl_o(a_pin), .b_lvl_o(b_pin),
      .c_lvl_o(c_pin), .d_lvl_o(d_pin), .e_lvl_o(e_pin));

   // ----------------------------------------------------------------
   // bus and compare tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // kind: 1 write, 2 bit set, 4 bit clear; bit index rides in d[2:0]
   task automatic op(input logic [5:0] a, input logic [7:0] d, input logic [2:0] kind);
      @(negedge mclk_i);
      io_addr_i = a;
      io_wdata_i = d;
      io_bit_i = d[2:0];
      {io_bclr_i, io_bset_i, io_wr_i} = kind;
      @(negedge mclk_i);
      {io_bclr_i, io_bset_i, io_wr_i} = 3'h0;
   endtask : op
   task automatic rdc(input logic [5:0] a, input logic [7:0] exp);
      @(negedge mclk_i);
      io_addr_i = a;
      io_rd_i = 1'b1;
      @(negedge mclk_i);
      io_rd_i = 1'b0;
      chk(io_rdata_o, exp);
   endtask : rdc
   // pads lag one cycle, pin sense two more
   task automatic settle();
      repeat (4) @(negedge mclk_i);
   endtask : settle

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_regs();
      for (int i = 0; i < 10; i++) rdc(rw_addr[i], 8'h00);
      for (int i = 0; i < 10; i++) op(rw_addr[i], 8'hff, 3'h1);
      for (int i = 0; i < 5; i++) op(pin_addr[i], 8'h00, 3'h1);
      for (int i = 0; i < 10; i++) rdc(rw_addr[i], rw_mask[i]);
      for (int i = 0; i < 10; i++) op(rw_addr[i], 8'h00, 3'h1);
      rdc(6'h05, 8'h00);
   endtask : t_regs
   task automatic t_drive();
      op(6'h1a, 8'hff, 3'h1);
      op(6'h1b, 8'h0f, 3'h1);
      op(6'h17, 8'h3c, 3'h1);
      settle();
      chk(a_oe, 8'hf0);
      chk(a_o, 8'h00);
      chk(b_oe, 8'h3c);
      rdc(6'h19, 8'h0f);
      rdc(6'h1b, 8'h0f);
      rdc(6'h16, 8'hc3);
   endtask : t_drive
   task automatic t_rows();
      settle();
      chk(c_pull, 8'hff);
      rdc(6'h13, 8'hff);
      key_dn = 1'b1;
      settle();
      rdc(6'h13, 8'hdf);
      op(6'h14, 8'h01, 3'h1);
      settle();
      chk(c_oe, 8'h01);
      chk(c_o, 8'h00);
      rdc(6'h13, 8'hde);
      key_dn = 1'b0;
   endtask : t_rows
   task automatic t_sync();
      @(negedge mclk_i);
      ext_e = 8'hff;
      rdc(6'h01, 8'h00);
      rdc(6'h01, 8'hf3);
   endtask : t_sync
   task automatic t_bits();
      op(6'h17, 8'h55, 3'h1);
      op(6'h17, 8'h01, 3'h2);
      op(6'h17, 8'h00, 3'h4);
      rdc(6'h17, 8'h56);
      op(6'h02, 8'h02, 3'h2);
      rdc(6'h02, 8'h00);
      op(6'h19, 8'h07, 3'h2);
      rdc(6'h1b, 8'h0f);
   endtask : t_bits
   task automatic t_port_d_out_latch();
      op(6'h11, 8'hff, 3'h1);
      op(6'h12, 8'h02, 3'h1);
      settle();
      chk({6'h00, d_oe}, 8'h03);
      chk({6'h00, d_o}, 8'h02);
      rdc(6'h10, 8'h02);
   endtask : t_port_d_out_latch
   // write then read on the next cycle; a read in the write cycle sees the old latch
   task automatic t_b2b();
      @(negedge mclk_i);
      io_addr_i = 6'h1b;
      io_wdata_i = 8'ha5;
      io_wr_i = 1'b1;
      io_rd_i = 1'b1;
      @(negedge mclk_i);
      io_wr_i = 1'b0;
      chk(io_rdata_o, 8'h0f);
      @(negedge mclk_i);
      io_rd_i = 1'b0;
      chk(io_rdata_o, 8'ha5);
   endtask : t_b2b
   task automatic t_leds();
      op(6'h02, 8'hff, 3'h1);
      op(6'h03, 8'h50, 3'h1);
      settle();
      chk(e_oe, 8'ha3);
      chk(e_o, 8'h00);
      chk(b_o, 8'h00);
      rdc(6'h01, 8'h50);
   endtask : t_leds

   // ----------------------------------------------------------------
   // clock, run and verdict
   // ----------------------------------------------------------------
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : tally_and_finish
   initial begin
      mclk_i = 1'b0;
      forever #20 mclk_i = ~mclk_i;
   end
   initial begin
      #800000;
      error_cnt++;
      tally_and_finish();
   end
   initial begin
      {arst_n_i, io_wr_i, io_rd_i, io_bset_i, io_bclr_i, key_dn} = 6'h00;
      {io_addr_i, io_wdata_i, io_bit_i} = 17'h0_0000;
      {ext_a, ext_b, ext_e, ext_d} = 26'h3ff_fc00;
      key_row = 3'd5;
      key_col = 3'd6;
      repeat (5) @(posedge mclk_i);
      @(negedge mclk_i);
      arst_n_i = 1'b1;
      t_regs();
      t_drive();
      t_rows();
      t_sync();
      t_bits();
      t_b2b();
      t_leds();
      t_port_d_out_latch();
      tally_and_finish();
   end
endmodule : test_keyboard_gpio_ports
`default_nettype wire
